// ---- iem_pkg.sv ----
// Package of register map and field constants for the second interrupt masks
package iem_pkg;
  localparam logic [7:0] IEM_ADDR_SUPPLY_CFG = 8'h7D;
  localparam logic [7:0] IEM_ADDR_LED_COMPL  = 8'h7E;
  localparam logic [7:0] IEM_ADDR_CHIP_ID    = 8'hFF;
  localparam int         IEM_BIT_NINTH       = 7;
  localparam int         IEM_BIT_SUPPLY      = 6;
  localparam int         IEM_BIT_BAD_SETUP   = 2;
  localparam logic [7:0] IEM_SUPPLY_CFG_MASK = 8'hC4;
  localparam logic [7:0] IEM_RESET_VAL       = 8'h00;
  // Arbitrary neutral identification value
  localparam logic [7:0] IEM_CHIP_ID_DEFAULT = 8'h5A;
endpackage

// ---- iem_second_irq_output_enable_mask.sv ----
// Second interrupt output enable masks and chip identifier register
// Function
// - Second irq rises on enabled status-2 flags, bits 7, 6 and 2.
// - Supply monitor off when both supply range enables are zero.
// - Mask 0x7E gates eight compliance flags; resets zero, read/write.
// - Read-only chip identifier at 0xFF; writes are ignored.
`timescale 1ns/10ps
`default_nettype none
module iem_second_irq_output_enable_mask
  import iem_pkg::*;
#(
  parameter logic [7:0] CHIP_ID_CODE = IEM_CHIP_ID_DEFAULT,
  parameter int         DRIVER_COUNT = 8
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wr_data,
  output logic      [7:0] reg_rd_data,
  input  wire logic       supply_out_of_range_flag,
  input  wire logic       bad_setup_flag,
  input  wire logic       ninth_driver_compliance_flag,
  input  wire logic [7:0] driver_compliance_flag_n,
  input  wire logic       supply_range_irq_a_en,
  input  wire logic       pulse_warning_irq_b_en,
  output logic            supply_monitor_enable,
  output logic            second_irq_output
);

  // Ports and masks are one byte wide, so only eight drivers fit
  generate
    if (DRIVER_COUNT != 8) begin : g_bad_count
      $error("DRIVER_COUNT must be 8 to fit one register");
    end
  endgenerate

  logic [7:0] mask_supply_cfg_q;
  logic [7:0] mask_led_compl_q;
  logic [7:0] led_hits;
  logic       status2_hit;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] t);
    return a == t;
  endfunction

  // Only writable bits are stored, so reserved bits read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_supply_cfg_q <= IEM_RESET_VAL;
    end else if (reg_wr_en && addr_hit(reg_addr, IEM_ADDR_SUPPLY_CFG)) begin
      mask_supply_cfg_q <= reg_wr_data & IEM_SUPPLY_CFG_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask_led_compl_q <= IEM_RESET_VAL;
    end else if (reg_wr_en && addr_hit(reg_addr, IEM_ADDR_LED_COMPL)) begin
      mask_led_compl_q <= reg_wr_data;
    end
  end

  // Chip identifier has no storage; writes fall through
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rd_data <= IEM_RESET_VAL;
    end else if (reg_rd_en) begin
      case (reg_addr)
        IEM_ADDR_SUPPLY_CFG: reg_rd_data <= mask_supply_cfg_q;
        IEM_ADDR_LED_COMPL:  reg_rd_data <= mask_led_compl_q;
        IEM_ADDR_CHIP_ID:    reg_rd_data <= CHIP_ID_CODE;
        default:             reg_rd_data <= IEM_RESET_VAL;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DRIVER_COUNT; gi++) begin : g_led
      assign led_hits[gi] = driver_compliance_flag_n[gi]
                          & mask_led_compl_q[gi];
    end
  endgenerate

  assign status2_hit =
      (ninth_driver_compliance_flag & mask_supply_cfg_q[IEM_BIT_NINTH])
    | (supply_out_of_range_flag & mask_supply_cfg_q[IEM_BIT_SUPPLY])
    | (bad_setup_flag & mask_supply_cfg_q[IEM_BIT_BAD_SETUP]);

  // Pulse warning enable is combined here; software keeps others clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      second_irq_output <= 1'h0;
    end else begin
      second_irq_output <= status2_hit | (|led_hits)
                         | pulse_warning_irq_b_en;
    end
  end

  // Monitor runs while either output could still report a supply fault
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      supply_monitor_enable <= 1'h0;
    end else begin
      supply_monitor_enable <= supply_range_irq_a_en
                             | mask_supply_cfg_q[IEM_BIT_SUPPLY];
    end
  end

  property p_status2_irq;
    @(posedge sys_clk) disable iff (sys_rst)
      status2_hit |=> second_irq_output;
  endproperty
  a_status2_irq: assert property (p_status2_irq)
    else $error("enabled status-2 flag did not raise irq");

  property p_monitor_off;
    @(posedge sys_clk) disable iff (sys_rst)
      (!supply_range_irq_a_en && !mask_supply_cfg_q[IEM_BIT_SUPPLY])
        |=> !supply_monitor_enable;
  endproperty
  a_monitor_off: assert property (p_monitor_off)
    else $error("supply monitor not powered down");

  property p_led_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == IEM_ADDR_LED_COMPL)
        |=> mask_led_compl_q == $past(reg_wr_data);
  endproperty
  a_led_write: assert property (p_led_write)
    else $error("led mask write lost");

  sequence s_id_read;
    reg_rd_en && reg_addr == IEM_ADDR_CHIP_ID;
  endsequence
  property p_chip_id;
    @(posedge sys_clk) disable iff (sys_rst)
      s_id_read |=> reg_rd_data == CHIP_ID_CODE;
  endproperty
  a_chip_id: assert property (p_chip_id)
    else $error("chip identifier read wrong");

  property p_irq_cause;
    @(posedge sys_clk) disable iff (sys_rst)
      second_irq_output |-> $past(status2_hit | (|led_hits)
                                  | pulse_warning_irq_b_en);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq raised without enabled flag");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (mask_supply_cfg_q & ~IEM_SUPPLY_CFG_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved mask bit set");

  property p_supply_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr_en && addr_hit(reg_addr, IEM_ADDR_SUPPLY_CFG))
        |=> mask_supply_cfg_q == ($past(reg_wr_data) & IEM_SUPPLY_CFG_MASK);
  endproperty
  a_supply_write: assert property (p_supply_write)
    else $error("supply mask write lost or reserved bit kept");

  property p_supply_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !(reg_wr_en && addr_hit(reg_addr, IEM_ADDR_SUPPLY_CFG))
        |=> $stable(mask_supply_cfg_q);
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("supply mask changed without write");

  property p_led_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !(reg_wr_en && addr_hit(reg_addr, IEM_ADDR_LED_COMPL))
        |=> $stable(mask_led_compl_q);
  endproperty
  a_led_hold: assert property (p_led_hold)
    else $error("led mask changed without write");

  property p_led_irq;
    @(posedge sys_clk) disable iff (sys_rst)
      (|led_hits) |=> second_irq_output;
  endproperty
  a_led_irq: assert property (p_led_irq)
    else $error("enabled driver flag did not raise irq");

  // Sampled reset keeps the release edge, monitor still held off, out
  property p_monitor_on;
    @(posedge sys_clk) disable iff (sys_rst)
      !sys_rst
        && (supply_range_irq_a_en || mask_supply_cfg_q[IEM_BIT_SUPPLY])
        |=> supply_monitor_enable;
  endproperty
  a_monitor_on: assert property (p_monitor_on)
    else $error("supply monitor off while an enable is set");

  sequence s_unmapped_read;
    reg_rd_en && !addr_hit(reg_addr, IEM_ADDR_SUPPLY_CFG)
      && !addr_hit(reg_addr, IEM_ADDR_LED_COMPL)
      && !addr_hit(reg_addr, IEM_ADDR_CHIP_ID);
  endsequence
  property p_unmapped_read;
    @(posedge sys_clk) disable iff (sys_rst)
      s_unmapped_read |=> reg_rd_data == IEM_RESET_VAL;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_rd_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !reg_rd_en |=> $stable(reg_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");

  sequence s_id_write;
    reg_wr_en && addr_hit(reg_addr, IEM_ADDR_CHIP_ID);
  endsequence
  property p_id_write_ignored;
    @(posedge sys_clk) disable iff (sys_rst)
      s_id_write |=> $stable(mask_supply_cfg_q) && $stable(mask_led_compl_q);
  endproperty
  a_id_write_ignored: assert property (p_id_write_ignored)
    else $error("identifier write disturbed a mask");

endmodule
`default_nettype wire

// ---- iem_host_model.sv ----
// Host model that samples the second interrupt pin
`timescale 1ns/10ps
`default_nettype none
module iem_host_model (
  input  wire logic sys_clk,
  input  wire logic second_irq_output,
  output logic      irq_seen_q
);
  always_ff @(posedge sys_clk) begin
    irq_seen_q <= second_irq_output;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the second interrupt masks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import iem_pkg::*;
  logic        sys_clk = 0, sys_rst = 1, wr = 0, rd = 0, pend = 0;
  logic        sf = 0, bf = 0, nf = 0, sa = 0, pw = 0;
  logic        mon, irq, seen, ex_i;
  logic [7:0]  addr = 8'h00, wd = 8'h00, df = 8'h00, rdd, m1, m2;
  logic [10:0] exp_q[$];
  logic [10:0] e, got;
  logic [31:0] s = 32'h169F2;
  int          n_fail = 0, checked = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  iem_second_irq_output_enable_mask DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wr_data(wd),
    .reg_rd_data(rdd), .supply_out_of_range_flag(sf),
    .bad_setup_flag(bf), .ninth_driver_compliance_flag(nf),
    .driver_compliance_flag_n(df), .supply_range_irq_a_en(sa),
    .pulse_warning_irq_b_en(pw), .supply_monitor_enable(mon),
    .second_irq_output(irq));
  iem_host_model HOST (.sys_clk(sys_clk), .second_irq_output(irq),
    .irq_seen_q(seen));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic end_sim();
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Strobes are single pulses; idle edge keeps writes visible before reads
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge sys_clk);
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] v);
    ex_i = |({nf, sf, bf} & {m1[7], m1[6], m1[2]}) | (|(df & m2)) | pw;
    exp_q.push_back({m1[6] | sa, ex_i, ex_i, v});
    bus(1'h0, a, 8'h00);
  endtask
  always @(posedge sys_clk) begin
    pend <= rd;
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  always @(negedge sys_clk) begin
    if (pend) begin
      e = exp_q.pop_front();
      got = {mon, irq, seen, rdd};
      checked = checked + 1;
      if (got !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch outputs exp %h got %h", e, got);
      end
    end
  end
  initial begin
    m1 = 8'h00;
    m2 = 8'h00;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rchk(IEM_ADDR_SUPPLY_CFG, 8'h00);
    rchk(IEM_ADDR_LED_COMPL, 8'h00);
    bus(1'h1, IEM_ADDR_CHIP_ID, 8'hA5);
    rchk(IEM_ADDR_CHIP_ID, IEM_CHIP_ID_DEFAULT);
    rchk(8'h10, 8'h00);
    for (int i = 0; i < 60; i++) begin
      s = lfsr(s);
      {sf, bf, nf, sa} <= s[3:0];
      pw <= s[4] & s[5];
      df <= s[13:6];
      // Both mask enables stay clear while pulse warning is on; sa stays random
      m1 = (s[4] & s[5]) ? 8'h00 : s[21:14];
      m2 = (s[4] & s[5]) ? 8'h00 : s[29:22];
      bus(1'h1, IEM_ADDR_SUPPLY_CFG, m1);
      bus(1'h1, IEM_ADDR_LED_COMPL, m2);
      m1 = m1 & IEM_SUPPLY_CFG_MASK;
      rchk(IEM_ADDR_SUPPLY_CFG, m1);
      rchk(IEM_ADDR_LED_COMPL, m2);
    end
    // Mid-run reset must clear both masks while flags stay up
    sys_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    m1 = 8'h00;
    m2 = 8'h00;
    @(posedge sys_clk);
    rchk(IEM_ADDR_LED_COMPL, 8'h00);
    rchk(IEM_ADDR_SUPPLY_CFG, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
